// ==== hw/relfc_pkg.sv ====
// package: constants for the remap entry low field check block
package relfc_pkg;

  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_MASK       = 8'h08;
  localparam logic [7:0] ADDR_FAULT_CNT  = 8'h0c;
  localparam logic [7:0] ADDR_LAST       = 8'h10;

  localparam int BIT_VALID    = 0;
  localparam int BIT_SUPPRESS = 1;
  localparam int BIT_DEST_SEL = 2;

  localparam int ST_FAULT     = 0;
  localparam int ST_ADMIT     = 1;
  localparam int ST_SUPPRESS  = 2;
  localparam int ST_WIDTH     = 3;

  localparam logic [0:0]          CTRL_RESET   = 1'h1;
  localparam logic [ST_WIDTH-1:0] STATUS_RESET = 3'h0;
  localparam logic [ST_WIDTH-1:0] MASK_RESET   = 3'h0;

  localparam int ENTRY_LOW_W = 3;

  typedef enum logic [1:0] {
    RELFC_IDLE  = 2'b00,
    RELFC_SETUP = 2'b01,
    RELFC_ACC   = 2'b11
  } relfc_apb_t;

endpackage : relfc_pkg

// ==== hw/relfc_decode.sv ====
// module: combinational decode of the low entry control bits
`timescale 1ns/10ps
`default_nettype none
module relfc_decode
  import relfc_pkg::*;
(
  input  wire logic [ENTRY_LOW_W-1:0] entry_low,
  output logic                        admit,
  output logic                        fault,
  output logic                        suppressed,
  output logic                        logical_dest
);

  wire valid_bit    = entry_low[BIT_VALID];
  wire suppress_bit = entry_low[BIT_SUPPRESS];

  assign admit        = valid_bit;
  // suppress checked whether or not the entry is valid
  assign suppressed   = suppress_bit;
  assign fault        = !valid_bit && !suppress_bit;
  // destination sense forced to physical for invalid entries
  assign logical_dest = valid_bit && entry_low[BIT_DEST_SEL];

endmodule : relfc_decode
`default_nettype wire

// ==== hw/relfc_top.sv ====
// module: remap entry low field check with apb registers and interrupt
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - dest bit: 0 physical, 1 logical
// - dest bit ignored unless entry valid
// - suppress bit 0 reports faults, 1 hides
// - suppress bit only checked for invalid entries
// - invalid entry blocks every request
// - valid entry lets request proceed
module relfc_top
  import relfc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   req_valid,
  input  wire logic [ENTRY_LOW_W-1:0] remap_entry,
  output logic                        req_admit,
  output logic                        req_block,
  output logic                        interrupt_target_logical,
  output logic                        fault_record,
  output logic                        irq
);

  logic                   enable;
  logic [ST_WIDTH-1:0]    status;
  logic [ST_WIDTH-1:0]    mask;
  logic [CNT_W-1:0]       fault_cnt;
  logic [ENTRY_LOW_W-1:0] last_entry;
  relfc_apb_t             apb_state;
  relfc_apb_t             next_apb_state;

  wire dec_admit;
  wire dec_fault;
  wire dec_supp;
  wire dec_logical;

  relfc_decode u_decode (
    .entry_low    (remap_entry),
    .admit        (dec_admit),
    .fault        (dec_fault),
    .suppressed   (dec_supp),
    .logical_dest (dec_logical)
  );

  // request path; enable lets software hold off all checking
  wire req_go     = req_valid && enable;
  wire next_admit = req_go && dec_admit;
  wire next_block = req_go && !dec_admit;
  wire next_fault = req_go && dec_fault;
  wire next_supp  = req_go && !dec_admit && dec_supp;

  // apb decode
  wire acc     = psel && penable;
  wire wr      = acc && pwrite;
  wire wr_ctrl = wr && (paddr == ADDR_CTRL);
  wire wr_stat = wr && (paddr == ADDR_STATUS);
  wire wr_mask = wr && (paddr == ADDR_MASK);
  wire in_setup = psel && !penable;
  wire mapped  = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_MASK)
              || (paddr == ADDR_FAULT_CNT) || (paddr == ADDR_LAST);

  wire [ST_WIDTH-1:0] events      = {next_supp, next_admit, next_fault};
  wire [ST_WIDTH-1:0] w1c         = wr_stat ? pwdata[ST_WIDTH-1:0] : '0;
  // set wins over a clear in the same cycle
  wire [ST_WIDTH-1:0] next_status = (status & ~w1c) | events;

  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;
  assign irq     = |(status & mask);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      enable                   <= CTRL_RESET;
      status                   <= STATUS_RESET;
      mask                     <= MASK_RESET;
      fault_cnt                <= '0;
      last_entry               <= '0;
      req_admit                <= 1'b0;
      req_block                <= 1'b0;
      interrupt_target_logical <= 1'b0;
      fault_record             <= 1'b0;
    end else begin
      status       <= next_status;
      req_admit    <= next_admit;
      req_block    <= next_block;
      fault_record <= next_fault;
      if (next_admit) begin
        interrupt_target_logical <= dec_logical;
      end
      if (next_fault) begin
        fault_cnt <= fault_cnt + 1'b1;
      end
      if (req_go) begin
        last_entry <= remap_entry;
      end
      if (wr_ctrl) begin
        enable <= pwdata[0];
      end
      if (wr_mask) begin
        mask <= pwdata[ST_WIDTH-1:0];
      end
    end
  end

  // bus phase tracker; lets the checks below see where a transfer stands
  always_comb begin
    next_apb_state = RELFC_IDLE;
    case (apb_state)
      RELFC_IDLE: begin
        if (in_setup) begin
          next_apb_state = RELFC_SETUP;
        end
      end
      RELFC_SETUP: begin
        if (acc) begin
          next_apb_state = RELFC_ACC;
        end
      end
      RELFC_ACC: begin
        if (in_setup) begin
          next_apb_state = RELFC_SETUP;
        end
      end
      default: begin
        next_apb_state = RELFC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      apb_state <= RELFC_IDLE;
    end else begin
      apb_state <= next_apb_state;
    end
  end

  // read data from flops, loaded in setup; zero on unmapped, held when idle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (in_setup && !pwrite) begin
      case (paddr)
        ADDR_CTRL:      prdata <= {31'h0, enable};
        ADDR_STATUS:    prdata <= {29'h0, status};
        ADDR_MASK:      prdata <= {29'h0, mask};
        ADDR_FAULT_CNT: prdata <= {{(32-CNT_W){1'b0}}, fault_cnt};
        ADDR_LAST:      prdata <= {29'h0, last_entry};
        default:        prdata <= '0;
      endcase
    end
  end

  // entry that must leave a fault record behind
  function automatic logic fault_case(input logic [ENTRY_LOW_W-1:0] e);
    return !e[BIT_VALID] && !e[BIT_SUPPRESS];
  endfunction : fault_case

  property p_block_invalid;
    @(posedge ref_clk) disable iff (rst)
    (req_go && !remap_entry[BIT_VALID]) |=> (req_block && !req_admit);
  endproperty
  a_block_invalid: assert property (p_block_invalid)
    else $error("invalid entry not blocked");

  property p_admit_valid;
    @(posedge ref_clk) disable iff (rst)
    (req_go && remap_entry[BIT_VALID]) |=> (req_admit && !req_block);
  endproperty
  a_admit_valid: assert property (p_admit_valid)
    else $error("valid entry not admitted");

  property p_fault_raise;
    @(posedge ref_clk) disable iff (rst)
    (req_go && fault_case(remap_entry)) |=> (fault_record && status[ST_FAULT]);
  endproperty
  a_fault_raise: assert property (p_fault_raise)
    else $error("fault not recorded");

  property p_fault_supp;
    @(posedge ref_clk) disable iff (rst)
    fault_record |-> $past(!remap_entry[BIT_SUPPRESS] && req_go);
  endproperty
  a_fault_supp: assert property (p_fault_supp)
    else $error("fault reported while suppressed");

  property p_supp_any;
    @(posedge ref_clk) disable iff (rst)
    (req_go && !remap_entry[BIT_VALID] && remap_entry[BIT_SUPPRESS]) |=> status[ST_SUPPRESS];
  endproperty
  a_supp_any: assert property (p_supp_any)
    else $error("suppress bit not evaluated");

  property p_dest;
    @(posedge ref_clk) disable iff (rst)
    (req_go && remap_entry[BIT_VALID]) |=> (interrupt_target_logical == $past(remap_entry[2]));
  endproperty
  a_dest: assert property (p_dest)
    else $error("destination sense wrong");

  property p_dest_hold;
    @(posedge ref_clk) disable iff (rst)
    (req_go && !remap_entry[BIT_VALID]) |=> $stable(interrupt_target_logical);
  endproperty
  a_dest_hold: assert property (p_dest_hold)
    else $error("dest bit used for invalid entry");

  property p_irq;
    @(posedge ref_clk) disable iff (rst)
    (req_go && fault_case(remap_entry) && mask[ST_FAULT] && !wr_mask) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked fault gave no interrupt");

  property p_idle_quiet;
    @(posedge ref_clk) disable iff (rst)
    !req_go |=> (!req_admit && !req_block && !fault_record);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("answer without an accepted request");

  property p_supp_quiet;
    @(posedge ref_clk) disable iff (rst)
    (req_go && remap_entry[BIT_SUPPRESS]) |=> !fault_record;
  endproperty
  a_supp_quiet: assert property (p_supp_quiet)
    else $error("fault recorded with suppress set");

  property p_supp_valid;
    @(posedge ref_clk) disable iff (rst)
    (req_go && remap_entry[BIT_VALID] && remap_entry[BIT_SUPPRESS]) |=> (req_admit && !fault_record);
  endproperty
  a_supp_valid: assert property (p_supp_valid)
    else $error("suppressed valid entry mishandled");

  property p_fault_count;
    @(posedge ref_clk) disable iff (rst)
    (req_go && fault_case(remap_entry)) |=> (fault_cnt == CNT_W'($past(fault_cnt) + 1'b1));
  endproperty
  a_fault_count: assert property (p_fault_count)
    else $error("fault count did not step");

  property p_count_hold;
    @(posedge ref_clk) disable iff (rst)
    !(req_go && fault_case(remap_entry)) |=> $stable(fault_cnt);
  endproperty
  a_count_hold: assert property (p_count_hold)
    else $error("fault count moved without a fault");

  property p_status_sticky;
    @(posedge ref_clk) disable iff (rst)
    !wr_stat |=> ((status & $past(status)) == $past(status));
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("status bit dropped without a clear");

  property p_set_wins;
    @(posedge ref_clk) disable iff (rst)
    (req_go && fault_case(remap_entry) && wr_stat && pwdata[ST_FAULT]) |=> status[ST_FAULT];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a fault event");

  property p_clear_w1c;
    @(posedge ref_clk) disable iff (rst)
    (wr_stat && !req_go) |=> ((status & $past(pwdata[ST_WIDTH-1:0])) == '0);
  endproperty
  a_clear_w1c: assert property (p_clear_w1c)
    else $error("status bit not cleared by write of one");

  property p_last_entry;
    @(posedge ref_clk) disable iff (rst)
    req_go |=> (last_entry == $past(remap_entry));
  endproperty
  a_last_entry: assert property (p_last_entry)
    else $error("last entry not captured");

  property p_err_phase;
    @(posedge ref_clk) disable iff (rst)
    pslverr |-> (apb_state == RELFC_SETUP);
  endproperty
  a_err_phase: assert property (p_err_phase)
    else $error("error response outside access phase");

  property p_rdata_hold;
    @(posedge ref_clk) disable iff (rst)
    (apb_state == RELFC_ACC) |-> $stable(prdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved at access edge");

  property p_irq_masked;
    @(posedge ref_clk) disable iff (rst)
    (mask == '0) |-> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt with all sources masked");

endmodule : relfc_top
`default_nettype wire

// ==== tb/relfc_req_model.sv ====
// file: request source model standing in for the i/o devices
`timescale 1ns/10ps
`default_nettype none
module relfc_req_model (
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [2:0] entry,
  output logic            req_valid,
  output logic      [2:0] remap_entry
);
  initial req_valid = 1'b0;
  initial remap_entry = 3'h0;
  // entry handed over whole; idle bus inverts each cycle, so stale values look valid every other cycle
  always @(posedge ref_clk) begin
    req_valid   <= go;
    remap_entry <= go ? entry : ~remap_entry;
  end
endmodule : relfc_req_model
`default_nettype wire

// ==== tb/testbench.sv ====
// file: self-checking testbench for the remap entry low field check
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import relfc_pkg::*;
  logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, go = 0, err, lg = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [2:0]  entry = 3'h0, remap_entry, lx;
  logic        req_valid, pready, pslverr, req_admit, req_block, logical, fault_record, irq;
  logic [3:0]  exq[$];
  int          n_mismatch = 0, num_checks = 0, nf = 0, seed = 33;
  relfc_top relfc_top_i (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_valid(req_valid), .remap_entry(remap_entry),
    .req_admit(req_admit), .req_block(req_block), .interrupt_target_logical(logical),
    .fault_record(fault_record), .irq(irq));
  relfc_req_model relfc_req_model_i (.ref_clk(ref_clk), .go(go), .entry(entry),
    .req_valid(req_valid), .remap_entry(remap_entry));
  initial forever #25 ref_clk = ~ref_clk;
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  // note the expected answer as the request leaves; logical only moves on admit
  task rq(input logic [2:0] x);
    go <= 1'b1;
    entry <= x;
    lx = x;
    if (x[0]) lg = x[2];
    nf = nf + int'(!x[0] && !x[1]);
    exq.push_back({x[0], !x[0], !x[0] && !x[1], lg});
    @(posedge ref_clk);
  endtask : rq
  always @(posedge ref_clk) if (req_admit === 1'b1 || req_block === 1'b1) begin
    if (exq.size() == 0) chk("unexpected answer", 32'h1, 32'h0);
    else chk("answer", {req_admit, req_block, fault_record, logical}, exq.pop_front());
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'(CTRL_RESET));
    apb(1'b0, ADDR_MASK, 32'h0);
    chk("mask reset", rd, 32'(MASK_RESET));
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test done: registers");
    for (int i = 0; i < 8; i++) rq(3'(i));
    repeat (24) rq(3'($random(seed)));
    go <= 1'b0;
    repeat (4) @(posedge ref_clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", rd, 32'h7);
    apb(1'b0, ADDR_FAULT_CNT, 32'h0);
    chk("fault count", rd, 32'(nf));
    apb(1'b0, ADDR_LAST, 32'h0);
    chk("last entry", rd, 32'(lx));
    chk("irq masked", 32'(irq), 32'h0);
    apb(1'b1, ADDR_MASK, 32'h1);
    @(posedge ref_clk);
    chk("irq raised", 32'(irq), 32'h1);
    apb(1'b1, ADDR_STATUS, 32'h7);
    @(posedge ref_clk);
    chk("irq cleared", 32'(irq), 32'h0);
    $display("test done: requests and interrupt");
    apb(1'b1, ADDR_CTRL, 32'h0);
    rq(3'h0);
    exq.delete();
    go <= 1'b0;
    repeat (4) @(posedge ref_clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status when off", rd, 32'h0);
    $display("test done: disabled");
    end_sim();
  end
  // whole run is near 76 cycles; this limit only catches a hang
  initial begin
    repeat (2000) @(posedge ref_clk);
    n_mismatch++;
    end_sim();
  end
endmodule : testbench
`default_nettype wire
